// ---- dv/host_feed.sv ----
`timescale 1ns/1ps
module host_feed (
   input  wire logic        pclk,
   input  wire logic        in_ready,
   output logic [31:0]      in_data,
   output logic             in_valid
);
   initial begin
      in_data  = 32'h0000_0000;
      in_valid = 1'b0;
   end

   // ----------------------------------------------------------------
   // data pattern, distinct per word, same byte value in every lane
   // ----------------------------------------------------------------
   function automatic logic [31:0] pat(input int k);
      return 32'h0101_0101 * 32'(k + 1);
   endfunction

   // word is taken at the rising edge that sees in_ready high
   task automatic put(input logic [31:0] w, inout int errs);
      int n;
      @(posedge pclk);
      in_data  <= w;
      in_valid <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge pclk);
         if (in_ready === 1'b1) break;
      end
      if (n == 100) errs++;
      in_valid <= 1'b0;
      in_data  <= ~w;   // a stale word must never look valid
   endtask

   // reserved bits of command a are set on purpose
   task automatic send(input logic [1:0] o, input bit fs, input bit ls, input logic [10:0] c,
                       input logic [31:0] cmd_b, inout int errs);
      logic [31:0] cmd_a;
      int          k;
      cmd_a = 32'hFFFC_C800 | {14'h0000, o, 2'b00, fs, ls, 1'b0, c};
      put(cmd_a, errs);
      put(cmd_b, errs);
      for (k = 0; k < (o + c + 3) / 4; k++) begin
         put(pat(k), errs);
      end
   endtask
endmodule

// ---- dv/tx_buffer_command_a_parser_bench.sv ----
`timescale 1ns/1ps
module tx_buffer_command_a_parser_bench;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic [31:0] in_data;
   logic        in_valid;
   logic        in_ready;
   logic [31:0] mac_data;
   logic [3:0]  mac_be;
   logic        mac_valid;
   logic        mac_last;
   logic        mac_ready = 1'b0;
   logic        ep_error_report;
   logic [31:0] rd;
   logic        er;
   int          num_errors = 0;
   int          n_compared = 0;
   int          ep_cnt     = 0;
   int          cyc        = 0;
   logic [36:0] outq[$];

   tx_cmd_parser i_tx_cmd_parser (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready),
      .mac_data(mac_data), .mac_be(mac_be), .mac_valid(mac_valid), .mac_last(mac_last),
      .mac_ready(mac_ready), .ep_error_report(ep_error_report));

   host_feed i_host_feed (.pclk(pclk), .in_ready(in_ready), .in_data(in_data), .in_valid(in_valid));

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // mac stalls every third cycle so output words back up
   always @(posedge pclk) begin
      cyc       <= cyc + 1;
      mac_ready <= (cyc % 3) != 0;
      if (ep_error_report === 1'b1) ep_cnt <= ep_cnt + 1;
      if (mac_valid === 1'b1 && mac_ready === 1'b1) outq.push_back({mac_last, mac_be, mac_data});
   end

   // ----------------------------------------------------------------
   // common tasks
   // ----------------------------------------------------------------
   task automatic give_verdict();
      if (num_errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [36:0] seen, input logic [36:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 50) begin
         num_errors++;
         give_verdict();
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic feed(input logic [1:0] o, input bit fs, input bit ls, input logic [10:0] c,
                       input logic [31:0] b);
      int e;
      e = 0;
      i_host_feed.send(o, fs, ls, c, b, e);
      if (e != 0) begin
         num_errors += e;
         give_verdict();
      end
   endtask

   task automatic expect_buf(input int o, input int c, input bit ls);
      int          k;
      int          l;
      int          n;
      logic [3:0]  be;
      logic [31:0] m;
      logic [36:0] got;
      for (k = 0; k < (o + c + 3) / 4; k++) begin
         for (l = 0; l < 4; l++) begin
            be[l]        = (4 * k + l >= o) && (4 * k + l < o + c);
            m[8 * l +: 8] = {8{be[l]}};
         end
         if (be != 4'h0) begin
            for (n = 0; n < 100 && outq.size() == 0; n++) @(posedge pclk);
            if (n == 100) begin
               num_errors++;
               give_verdict();
            end
            got = outq.pop_front();
            chk({got[36:32], got[31:0] & m}, {ls && (k == (o + c + 3) / 4 - 1), be, i_host_feed.pat(k) & m});
         end
      end
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      apb(1'b0, txcmd_pkg::ADDR_EVT_STS, 32'h0000_0000);
      chk(rd, txcmd_pkg::EVT_STS_RESET);
      apb(1'b0, txcmd_pkg::ADDR_INT_MASK, 32'h0000_0000);
      chk(rd, txcmd_pkg::INT_MASK_RESET);
      apb(1'b0, txcmd_pkg::ADDR_CTRL, 32'h0000_0000);
      chk(rd, txcmd_pkg::CTRL_RESET);
      apb(1'b0, 12'h040, 32'h0000_0000);
      chk({er, rd}, 33'h0_0000_0000 | {1'b1, 32'h0000_0000});
      apb(1'b1, txcmd_pkg::ADDR_CTRL, 32'h0000_0000);
      repeat (3) @(negedge pclk);
      chk(in_ready, 1'b0);
      apb(1'b1, txcmd_pkg::ADDR_CTRL, 32'h0000_0001);
      apb(1'b1, txcmd_pkg::ADDR_INT_MASK, 32'h0000_0001);
   endtask

   // every offset, single-segment frames of matching length
   task automatic t_offsets();
      int o;
      for (o = 0; o < 4; o++) begin
         feed(2'(o), 1'b1, 1'b1, 11'(5 + 2 * o), 32'(5 + 2 * o));
         expect_buf(o, 5 + 2 * o, 1'b1);
      end
      chk(37'(ep_cnt), 37'h0);
      chk(irq, 1'b0);
   endtask

   task automatic t_sum();
      feed(2'd1, 1'b1, 1'b0, 11'd6, 32'h0000_000A);
      expect_buf(1, 6, 1'b0);
      apb(1'b0, txcmd_pkg::ADDR_STATUS, 32'h0000_0000);
      chk(rd & 32'h0000_1FFF, 32'h0000_1006);
      feed(2'd2, 1'b0, 1'b1, 11'd4, 32'h0000_000A);
      expect_buf(2, 4, 1'b1);
      chk(37'(ep_cnt), 37'h0);
      feed(2'd0, 1'b1, 1'b0, 11'd7, 32'h0000_000A);
      expect_buf(0, 7, 1'b0);
      feed(2'd3, 1'b0, 1'b1, 11'd4, 32'h0000_000A);
      expect_buf(3, 4, 1'b1);
      apb(1'b0, txcmd_pkg::ADDR_EVT_STS, 32'h0000_0000);
      chk({ep_cnt[3:0], irq, rd}, {4'h1, 1'b1, 32'h0000_0001});
      apb(1'b1, txcmd_pkg::ADDR_EVT_STS, 32'h0000_0001);
      apb(1'b0, txcmd_pkg::ADDR_EVT_STS, 32'h0000_0000);
      chk({irq, rd}, 33'h0_0000_0000);
   endtask

   // lone buffer missing its frame length, then a continuation with no frame open
   task automatic t_errs();
      apb(1'b1, txcmd_pkg::ADDR_EVT_STS, 32'h0000_0001);
      feed(2'd2, 1'b1, 1'b1, 11'd5, 32'h0000_0006);
      expect_buf(2, 5, 1'b1);
      apb(1'b0, txcmd_pkg::ADDR_EVT_STS, 32'h0000_0000);
      chk({ep_cnt[3:0], irq, rd}, {4'h3, 1'b1, 32'h0000_0001});
      apb(1'b1, txcmd_pkg::ADDR_EVT_STS, 32'h0000_0001);
      feed(2'd1, 1'b0, 1'b1, 11'd4, 32'h0000_0004);
      expect_buf(1, 4, 1'b1);
      chk(37'(ep_cnt), 37'h4);
   endtask

   // checksum bit may differ between buffers, any other bit may not
   task automatic t_cmdb();
      feed(2'd0, 1'b1, 1'b0, 11'd4, 32'h0000_4008);
      expect_buf(0, 4, 1'b0);
      feed(2'd0, 1'b0, 1'b1, 11'd4, 32'h0000_0008);
      expect_buf(0, 4, 1'b1);
      chk(37'(ep_cnt), 37'h1);
      feed(2'd0, 1'b1, 1'b0, 11'd4, 32'h0000_0008);
      expect_buf(0, 4, 1'b0);
      feed(2'd0, 1'b0, 1'b1, 11'd4, 32'h0000_2008);
      expect_buf(0, 4, 1'b1);
      chk(37'(ep_cnt), 37'h2);
   endtask

   initial begin
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0000_0000;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_offsets();
      t_sum();
      t_cmdb();
      t_errs();
      give_verdict();
   end
endmodule

// ---- rtl/tx_cmd_parser.sv ----
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module tx_cmd_parser #(
   parameter int CNT_W = 11
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   input  wire logic [31:0] in_data,
   input  wire logic        in_valid,
   output logic             in_ready,
   output logic [31:0]      mac_data,
   output logic [3:0]       mac_be,
   output logic             mac_valid,
   output logic             mac_last,
   input  wire logic        mac_ready,
   output logic             ep_error_report
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   txcmd_pkg::parse_state_t st_reg, st_next;
   logic [31:0]      sts_reg, mask_reg, ctrl_reg;
   logic [31:0]      prdata_reg;
   logic             pready_reg, pslverr_reg, irq_reg;
   logic             in_ready_reg;
   logic [31:0]      out_data_reg;
   logic [3:0]       out_be_reg;
   logic             out_valid_reg, out_last_reg, ep_reg;
   logic [1:0]       off_reg;
   logic             seg_first_reg, seg_last_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W:0]   sum_reg;
   logic [CNT_W-1:0] len_reg;
   logic [31:0]      ref_b_reg;
   logic             open_reg;
   logic [CNT_W-1:0] words_reg;
   logic             first_word_reg;
   logic [1:0]       tail_reg;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire acc     = in_valid && in_ready_reg;
   wire acc_a   = acc && (st_reg == txcmd_pkg::ST_CMD_A);
   wire acc_b   = acc && (st_reg == txcmd_pkg::ST_CMD_B);
   wire acc_d   = acc && (st_reg == txcmd_pkg::ST_DATA);
   // only the defined fields are looked at; 31:18, 15:14, 11 dropped
   wire [1:0]       a_off   = in_data[txcmd_pkg::A_OFF_MSB:txcmd_pkg::A_OFF_LSB];
   wire             a_first = in_data[txcmd_pkg::A_FIRST_BIT];
   wire             a_last  = in_data[txcmd_pkg::A_LAST_BIT];
   wire [CNT_W-1:0] a_cnt   = in_data[txcmd_pkg::A_CNT_MSB:txcmd_pkg::A_CNT_LSB];
   wire [CNT_W-1:0] b_len   = in_data[txcmd_pkg::B_LEN_MSB:txcmd_pkg::B_LEN_LSB];
   wire [31:0]      b_cmp   = in_data & ~txcmd_pkg::B_CSUM_MASK;
   // offset plus count spans the words; the rest of the last word is filler
   wire [CNT_W+1:0] span    = {2'b00, cnt_reg} + {{CNT_W{1'b0}}, off_reg} + (CNT_W+2)'(3);
   wire [CNT_W-1:0] nwords  = span[CNT_W+1:2];
   wire [1:0]       tail    = 2'(cnt_reg) + off_reg;
   wire [CNT_W:0]   sum_new = seg_first_reg ? {1'b0, cnt_reg} : sum_reg + {1'b0, cnt_reg};
   wire             err_seq = !seg_first_reg && !open_reg;
   wire             err_b   = !seg_first_reg && open_reg && (b_cmp != ref_b_reg);
   wire             err_len = seg_last_reg && (sum_new != {1'b0, (seg_first_reg ? b_len : len_reg)});
   wire             err_evt = acc_b && (err_seq || err_b || err_len);

   // lane masks: leading lanes below the offset, trailing lanes past the tail
   wire [3:0] lead_mask = 4'hF << off_reg;
   wire [3:0] trail_mask = (tail_reg == 2'd0) ? 4'hF : ~(4'hF << tail_reg);
   wire       last_word  = (words_reg == CNT_W'(1));
   wire [3:0] be_now     = (first_word_reg ? lead_mask : 4'hF) & (last_word ? trail_mask : 4'hF);

   // ----------------------------------------------------------------
   // parser sequence
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      unique case (st_reg)
         txcmd_pkg::ST_CMD_A: if (acc) st_next = txcmd_pkg::ST_CMD_B;
         txcmd_pkg::ST_CMD_B: if (acc) st_next = (nwords == '0) ? txcmd_pkg::ST_CMD_A : txcmd_pkg::ST_DATA;
         txcmd_pkg::ST_DATA:  if (acc && last_word) st_next = txcmd_pkg::ST_CMD_A;
         default:             st_next = txcmd_pkg::ST_CMD_A;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg        <= txcmd_pkg::ST_CMD_A;
         off_reg       <= '0;
         seg_first_reg <= 1'b0;
         seg_last_reg  <= 1'b0;
         cnt_reg       <= '0;
      end else begin
         st_reg <= st_next;
         if (acc_a) begin
            off_reg       <= a_off;
            seg_first_reg <= a_first;
            seg_last_reg  <= a_last;
            cnt_reg       <= a_cnt;
         end
      end
   end

   // frame bookkeeping
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sum_reg   <= '0;
         len_reg   <= '0;
         ref_b_reg <= '0;
         open_reg  <= 1'b0;
      end else if (acc_b) begin
         sum_reg  <= sum_new;
         open_reg <= !seg_last_reg;
         if (seg_first_reg) begin
            len_reg   <= b_len;
            ref_b_reg <= b_cmp;
         end
      end
   end

   // data word counting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         words_reg      <= '0;
         first_word_reg <= 1'b0;
         tail_reg       <= '0;
      end else if (acc_b) begin
         words_reg      <= nwords;
         first_word_reg <= 1'b1;
         tail_reg       <= tail;
      end else if (acc_d) begin
         words_reg      <= words_reg - CNT_W'(1);
         first_word_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // output stage toward the mac
   // ----------------------------------------------------------------
   // a word with no live lane is swallowed, never presented
   wire fwd        = acc_d && (be_now != 4'h0);
   wire ovalid_nxt = fwd || (out_valid_reg && !mac_ready);
   // registered ready costs one bubble per forwarded data word; chosen to keep ports flop-driven
   wire ready_nxt  = ctrl_reg[txcmd_pkg::ENABLE_BIT] && !ovalid_nxt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid_reg <= 1'b0;
         out_data_reg  <= '0;
         out_be_reg    <= '0;
         out_last_reg  <= 1'b0;
         in_ready_reg  <= 1'b0;
      end else begin
         out_valid_reg <= ovalid_nxt;
         in_ready_reg  <= ready_nxt;
         if (fwd) begin
            out_data_reg <= in_data;
            out_be_reg   <= be_now;
            out_last_reg <= last_word && seg_last_reg;
         end
      end
   end

   // ----------------------------------------------------------------
   // apb slave and interrupt
   // ----------------------------------------------------------------
   wire setup    = psel && !penable;
   wire wr_en    = psel && penable && pready_reg && pwrite && !pslverr_reg;
   wire hit_sts  = (paddr == txcmd_pkg::ADDR_EVT_STS);
   wire hit_mask = (paddr == txcmd_pkg::ADDR_INT_MASK);
   wire hit_ctrl = (paddr == txcmd_pkg::ADDR_CTRL);
   wire hit_stat = (paddr == txcmd_pkg::ADDR_STATUS);
   wire mapped   = hit_sts || hit_mask || hit_ctrl || hit_stat;
   wire [31:0] stat_word = ({{(31-CNT_W){1'b0}}, sum_reg} << txcmd_pkg::ST_SUM_LSB)
                         | ({31'h0, open_reg} << txcmd_pkg::ST_OPEN_BIT)
                         | ({30'h0, off_reg} << txcmd_pkg::ST_OFF_LSB);
   wire [31:0] rd_mux = hit_sts  ? sts_reg :
                        hit_mask ? mask_reg :
                        hit_ctrl ? ctrl_reg :
                        hit_stat ? stat_word : 32'h0000_0000;
   wire [31:0] evt_vec = {31'h0, err_evt} << txcmd_pkg::TX_ERR_BIT;
   wire [31:0] clr_vec = (wr_en && hit_sts) ? pwdata : 32'h0000_0000;
   // set beats clear when both land together
   wire [31:0] sts_next = (sts_reg & ~clr_vec) | evt_vec;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= '0;
      end else begin
         pready_reg  <= setup;
         pslverr_reg <= setup && !mapped;
         if (setup) prdata_reg <= rd_mux;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sts_reg  <= txcmd_pkg::EVT_STS_RESET;
         mask_reg <= txcmd_pkg::INT_MASK_RESET;
         ctrl_reg <= txcmd_pkg::CTRL_RESET;
         irq_reg  <= 1'b0;
         ep_reg   <= 1'b0;
      end else begin
         sts_reg <= sts_next;
         if (wr_en && hit_mask) mask_reg <= pwdata;
         if (wr_en && hit_ctrl) ctrl_reg <= pwdata;
         irq_reg <= |(sts_next & mask_reg);
         ep_reg  <= err_evt;
      end
   end

   assign prdata        = prdata_reg;
   assign pready        = pready_reg;
   assign pslverr       = pslverr_reg;
   assign irq           = irq_reg;
   assign in_ready      = in_ready_reg;
   assign mac_data      = out_data_reg;
   assign mac_be        = out_be_reg;
   assign mac_valid     = out_valid_reg;
   assign mac_last      = out_last_reg;
   assign ep_error_report = ep_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_lead_lanes;
      fwd && first_word_reg |=> (out_be_reg & ~(4'hF << $past(off_reg))) == 4'h0;
   endproperty
   a_lead_lanes: assert property (p_lead_lanes) else $error("leading offset lane forwarded");

   property p_first_seg;
      acc_a |=> seg_first_reg == $past(in_data[txcmd_pkg::A_FIRST_BIT]);
   endproperty
   a_first_seg: assert property (p_first_seg) else $error("first segment bit not taken");

   property p_last_seg;
      acc_a |=> seg_last_reg == $past(in_data[txcmd_pkg::A_LAST_BIT])
                && cnt_reg == $past(in_data[txcmd_pkg::A_CNT_MSB:txcmd_pkg::A_CNT_LSB]);
   endproperty
   a_last_seg: assert property (p_last_seg) else $error("last segment or count not taken");

   property p_word_count;
      acc_b |=> words_reg == CNT_W'(({2'b00, $past(cnt_reg)} + $past(off_reg) + 3) >> 2);
   endproperty
   a_word_count: assert property (p_word_count) else $error("buffer word count wrong");

   property p_trail_lanes;
      fwd && last_word && (tail_reg != 2'd0) |=> out_be_reg[3] == 1'b0;
   endproperty
   a_trail_lanes: assert property (p_trail_lanes) else $error("filler lane forwarded");

   property p_sum;
      acc_b && !seg_first_reg |=> sum_reg == $past(sum_reg) + $past(cnt_reg);
   endproperty
   a_sum: assert property (p_sum) else $error("running sum not accumulated");

   property p_len_err;
      acc_b && seg_first_reg && seg_last_reg
         && (cnt_reg != in_data[txcmd_pkg::B_LEN_MSB:txcmd_pkg::B_LEN_LSB])
         |=> sts_reg[txcmd_pkg::TX_ERR_BIT] ##1 irq || !mask_reg[txcmd_pkg::TX_ERR_BIT];
   endproperty
   a_len_err: assert property (p_len_err) else $error("length mismatch not flagged");

   property p_b_err;
      acc_b && !seg_first_reg && open_reg && ((in_data & ~txcmd_pkg::B_CSUM_MASK) != ref_b_reg)
         |=> sts_reg[txcmd_pkg::TX_ERR_BIT] && ep_error_report;
   endproperty
   a_b_err: assert property (p_b_err) else $error("second word mismatch not flagged");

   property p_report;
      ep_error_report |-> sts_reg[txcmd_pkg::TX_ERR_BIT] && $past(acc_b);
   endproperty
   a_report: assert property (p_report) else $error("endpoint report without error");

   // a continuation buffer with no frame open can never be summed correctly
   property p_seq_err;
      acc_b && !seg_first_reg && !open_reg |=> sts_reg[txcmd_pkg::TX_ERR_BIT] && ep_error_report;
   endproperty
   a_seq_err: assert property (p_seq_err) else $error("orphan continuation buffer not flagged");

endmodule

// ---- shared/txcmd_pkg.sv ----
package txcmd_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_EVT_STS  = 12'h000;
   localparam logic [11:0] ADDR_INT_MASK = 12'h004;
   localparam logic [11:0] ADDR_CTRL     = 12'h008;
   localparam logic [11:0] ADDR_STATUS   = 12'h00C;

   localparam logic [31:0] EVT_STS_RESET  = 32'h0000_0000;
   localparam logic [31:0] INT_MASK_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRL_RESET     = 32'h0000_0001;

   // interrupt status / mask bit: transmit error
   localparam int TX_ERR_BIT = 0;
   // control: parser enable
   localparam int ENABLE_BIT = 0;
   // status fields
   localparam int ST_SUM_LSB  = 0;
   localparam int ST_OPEN_BIT = 12;
   localparam int ST_OFF_LSB  = 16;

   // ----------------------------------------------------------------
   // first command word layout
   // ----------------------------------------------------------------
   localparam int A_OFF_MSB   = 17;
   localparam int A_OFF_LSB   = 16;
   localparam int A_FIRST_BIT = 13;
   localparam int A_LAST_BIT  = 12;
   localparam int A_CNT_MSB   = 10;
   localparam int A_CNT_LSB   = 0;

   // ----------------------------------------------------------------
   // second command word layout
   // ----------------------------------------------------------------
   localparam int          B_LEN_MSB = 10;
   localparam int          B_LEN_LSB = 0;
   localparam logic [31:0] B_CSUM_MASK = 32'h0000_4000;

   typedef enum logic [1:0] {
      ST_CMD_A = 2'b00,
      ST_CMD_B = 2'b01,
      ST_DATA  = 2'b11
   } parse_state_t;

endpackage
